//--- rsfr_top.sv
// rail fault response: response selection, fault status, open-drain flag and switching gate
// Behaviour
// - global bit picks own fields, else mode pin
// - control bits 3:2 pick driver-rail undervoltage response
// - control bits 5:4 pick logic-rail overvoltage response
// - control bits 7:6 pick logic-rail undervoltage response
// - driver-rail undervoltage sets status bit 3, flag low
// - logic-rail overvoltage sets status bit 0, flag low
// - logic-rail undervoltage sets status bit 1, flag low
// - flag-only response keeps switching running
// - hiccup stops switching, resumes 500ms after clearing
// - latch-off stops switching until an enable toggles
`timescale 1ns/1ps
`default_nettype none
`include "rsfr_defines.svh"

module rsfr_top #(
	parameter int CNT_W = 24,
	parameter logic [CNT_W-1:0] HICCUP_CYCLES = CNT_W'(`RSFR_HICCUP_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register command port, same clock domain as the bus decoder
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	// global individual-response enable and mode-pin response, from on-chip logic
	input wire logic ind_resp_en,
	input wire logic [1:0] mode_resp,
	// comparator outputs, asynchronous
	input wire logic driver_supply_rail_uv,
	input wire logic logic_supply_rail_ov,
	input wire logic logic_supply_rail_uv,
	// enable pins, asynchronous
	input wire logic pwm_en,
	input wire logic chip_en,
	// open-drain fault flag
	input wire logic fault_flag_n_i,
	output logic fault_flag_n_o,
	output logic fault_flag_oe,
	// switching permitted
	output logic pwm_run
);

	localparam int NR = 3; // rails handled here

	logic [NR-1:0] det_raw; // comparator inputs gathered
	logic [NR-1:0] det_s; // synchronised: 0 drv uv, 1 logic ov, 2 logic uv
	logic [2:0] pin_s; // synchronised pwm_en, chip_en, flag pin
	logic pwm_en_s;
	logic chip_en_s;
	logic flag_pin_s;
	logic pwm_en_prev_q; // for falling-edge detection
	logic chip_en_prev_q;
	logic en_toggle; // one-cycle pulse when either enable drops

	logic [7:0] ctrl_q; // response control register
	logic [7:0] stat_q; // fault status register (bit 7 set while the pin is low)
	logic [7:0] stat_d;
	logic [1:0] eff_resp [NR]; // response each rail really uses
	logic [NR-1:0] stop; // per-rail stop requests
	logic [NR-1:0] stat_pos; // where each rail lands in status
	logic stat_clr_wr; // write to the status register

	assign det_raw = {logic_supply_rail_uv, logic_supply_rail_ov, driver_supply_rail_uv};
	assign pwm_en_s = pin_s[0];
	assign chip_en_s = pin_s[1];
	assign flag_pin_s = pin_s[2];

	// comparator levels cross into the clock domain first
	rsfr_sync #(
		.W(NR)
	) u_det_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d(det_raw),
		.q(det_s)
	);

	// enable pins and the shared flag wire likewise
	rsfr_sync #(
		.W(3)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({fault_flag_n_i, chip_en, pwm_en}),
		.q(pin_s)
	);

	// remember the enables to find a toggle; the latch clears on the drop,
	// so switching only returns once the controller raises it again
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_en_prev_q <= 1'b0;
			chip_en_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pwm_en_prev_q <= pwm_en_s;
			chip_en_prev_q <= chip_en_s;
		end
	end

	// toggle of either enable releases a latch-off
	assign en_toggle = (pwm_en_prev_q & ~pwm_en_s) | (chip_en_prev_q & ~chip_en_s);

	// response control register, written from the command port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= `RSFR_RST_RESP_CTRL;
		else if (clk_en && reg_wr && reg_addr == `RSFR_OFS_RESP_CTRL)
			ctrl_q <= reg_wdata;
	end

	// select per-rail responses; the mode pin governs when the global bit is off
	always_comb
	begin
		if (ind_resp_en)
		begin
			eff_resp[0] = ctrl_q[`RSFR_FLD_DRV_UV +: 2];
			eff_resp[1] = ctrl_q[`RSFR_FLD_LOGIC_OV +: 2];
			eff_resp[2] = ctrl_q[`RSFR_FLD_LOGIC_UV +: 2];
		end
		else
		begin
			eff_resp[0] = mode_resp;
			eff_resp[1] = mode_resp;
			eff_resp[2] = mode_resp;
		end
	end

	// one response engine per rail
	genvar gi;
	generate
		for (gi = 0; gi < NR; gi++)
		begin : g_rail
			rsfr_rail_resp #(
				.CNT_W(CNT_W),
				.HICCUP_CYCLES(HICCUP_CYCLES)
			) u_resp (
				.clk(clk),
				.rst_n(rst_n),
				.clk_en(clk_en),
				.fault(det_s[gi]),
				.resp(eff_resp[gi]),
				.en_toggle(en_toggle),
				.stop_q(stop[gi])
			);
		end
	endgenerate

	assign stat_clr_wr = reg_wr && reg_addr == `RSFR_OFS_FAULT_STAT;

	// status next value: write-one-to-clear, but a present fault wins over the clear
	always_comb
	begin
		stat_pos = '0;
		stat_d = stat_q;
		if (stat_clr_wr)
			stat_d = stat_q & ~reg_wdata;
		stat_d[`RSFR_STAT_DRV_UV] = stat_d[`RSFR_STAT_DRV_UV] | det_s[0];
		stat_d[`RSFR_STAT_LOGIC_OV] = stat_d[`RSFR_STAT_LOGIC_OV] | det_s[1];
		stat_d[`RSFR_STAT_LOGIC_UV] = stat_d[`RSFR_STAT_LOGIC_UV] | det_s[2];
		stat_d[`RSFR_STAT_FLAG_PIN] = ~flag_pin_s; // live wire level, set when low
		stat_d[2] = 1'b0; // unused positions read as zero
		stat_d[6:4] = 3'h0;
		stat_pos[0] = stat_d[`RSFR_STAT_DRV_UV];
		stat_pos[1] = stat_d[`RSFR_STAT_LOGIC_OV];
		stat_pos[2] = stat_d[`RSFR_STAT_LOGIC_UV];
	end

	// status register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stat_q <= `RSFR_RST_FAULT_STAT;
		else if (clk_en)
			stat_q <= stat_d;
	end

	// open-drain flag: pull low while any recorded rail fault stands
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_flag_oe <= 1'b0;
			fault_flag_n_o <= 1'b0;
		end
		else if (clk_en)
		begin
			fault_flag_oe <= |stat_pos;
			fault_flag_n_o <= 1'b0; // only ever drives low
		end
	end

	// switching gate: enables up and no rail asking to stop
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pwm_run <= 1'b0;
		else if (clk_en)
			pwm_run <= pwm_en_s & chip_en_s & ~(|stop);
	end

	// read port: one-cycle ack, unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 8'h00;
			reg_ack <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_ack <= reg_rd | reg_wr;
			if (reg_rd)
			begin
				unique case (reg_addr)
					`RSFR_OFS_RESP_CTRL: reg_rdata <= ctrl_q;
					`RSFR_OFS_FAULT_STAT: reg_rdata <= stat_q;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	AST_RESP_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
		ind_resp_en ? (eff_resp[0] == ctrl_q[3:2] && eff_resp[1] == ctrl_q[5:4] && eff_resp[2] == ctrl_q[7:6])
		: (eff_resp[0] == mode_resp && eff_resp[1] == mode_resp
		&& eff_resp[2] == mode_resp))
		else $error("effective response does not follow selection");

	AST_DRV_UV_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && det_s[0]) |=> (stat_q[3] && fault_flag_oe && !fault_flag_n_o))
		else $error("driver-rail undervoltage not recorded or flagged");

	AST_LOGIC_OV_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && det_s[1]) |=> (stat_q[0] && fault_flag_oe))
		else $error("logic-rail overvoltage not recorded or flagged");

	AST_LOGIC_UV_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && det_s[2] && stat_clr_wr) |=> (stat_q[1] && fault_flag_oe))
		else $error("logic-rail undervoltage lost against a clear");

	AST_STOP_GATES_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && |stop) |=> !pwm_run)
		else $error("switching allowed while a rail requests stop");

	// switching gate follows the enables and the stop requests
	AST_RUN_NEEDS_ENABLES: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && !(pwm_en_s && chip_en_s)) |=> !pwm_run)
		else $error("switching allowed with an enable low");

	AST_RUN_RESUMES: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && pwm_en_s && chip_en_s && !(|stop)) |=> pwm_run)
		else $error("switching held off with no stop request");

	// status clear and open-drain flag
	AST_STAT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && stat_clr_wr && reg_wdata[`RSFR_STAT_DRV_UV] && !det_s[0]) |=> !stat_q[`RSFR_STAT_DRV_UV])
		else $error("status bit survived a clear with no fault");

	AST_FLAG_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && !(|stat_pos)) |=> !fault_flag_oe)
		else $error("flag still pulled low with no recorded fault");

	AST_FLAG_DRIVES_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		fault_flag_oe |-> !fault_flag_n_o)
		else $error("flag driven high");

	AST_STAT_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		stat_q[2] == 1'b0 && stat_q[6:4] == 3'h0)
		else $error("unused status bit set");

	// register port answers every strobe for exactly one cycle
	AST_ACK_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && (reg_rd || reg_wr)) |=> reg_ack)
		else $error("strobe not acknowledged");

	AST_ACK_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && !reg_rd && !reg_wr) |=> !reg_ack)
		else $error("acknowledge without a strobe");

	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && reg_wr && reg_addr == `RSFR_OFS_RESP_CTRL) |=> ctrl_q == $past(reg_wdata))
		else $error("control write not stored");

	AST_RDATA_STAT: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && reg_rd && reg_addr == `RSFR_OFS_FAULT_STAT) |=> reg_rdata == $past(stat_q))
		else $error("status read returned wrong value");

endmodule : rsfr_top
`default_nettype wire

//--- rsfr_defines.svh
// register map, field positions, reset values and timing counts of the rail fault response block
`ifndef RSFR_DEFINES_SVH
`define RSFR_DEFINES_SVH

// register offsets on the command port
`define RSFR_OFS_RESP_CTRL 8'hB3
`define RSFR_OFS_FAULT_STAT 8'hD3

// response control field positions (low bit of each 2-bit field)
`define RSFR_FLD_DRV_UV 2
`define RSFR_FLD_LOGIC_OV 4
`define RSFR_FLD_LOGIC_UV 6

// fault status bit positions
`define RSFR_STAT_LOGIC_OV 0
`define RSFR_STAT_LOGIC_UV 1
`define RSFR_STAT_DRV_UV 3
`define RSFR_STAT_FLAG_PIN 7

// reset values
`define RSFR_RST_RESP_CTRL 8'h00
`define RSFR_RST_FAULT_STAT 8'h00

// hiccup recovery delay, in ms, and the clock rate that turns it into cycles
`define RSFR_HICCUP_MS 64'd500
`define RSFR_CLK_HZ 64'd25000000
`define RSFR_HICCUP_CYC ((`RSFR_HICCUP_MS * `RSFR_CLK_HZ) / 64'd1000)

`endif

//--- rsfr_pkg.sv
// types shared by the rail fault response block
`default_nettype none

package rsfr_pkg;

	// per-fault response codes, as held in each 2-bit control field
	typedef enum logic [1:0] {
		RSFR_RESP_FLAG = 2'h0,
		RSFR_RESP_HICCUP = 2'h1,
		RSFR_RESP_LATCH = 2'h2,
		RSFR_RESP_FLAG_ALT = 2'h3
	} rsfr_resp_t;

	// per-rail response state, gray along run -> hold -> wait and run <-> latched
	typedef enum logic [1:0] {
		RSFR_ST_RUN = 2'h0,
		RSFR_ST_HOLD = 2'h1,
		RSFR_ST_WAIT = 2'h3,
		RSFR_ST_LATCHED = 2'h2
	} rsfr_state_t;

endpackage : rsfr_pkg
`default_nettype wire

//--- rsfr_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none

module rsfr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q; // first stage, read only by the second

	// plain double register; reset to idle-low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else if (clk_en)
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : rsfr_sync
`default_nettype wire

//--- rsfr_rail_resp.sv
// one rail's fault response engine: flag only, hiccup with restart delay, or latch-off
`timescale 1ns/1ps
`default_nettype none
`include "rsfr_defines.svh"

module rsfr_rail_resp #(
	parameter int CNT_W = 24,
	parameter logic [CNT_W-1:0] HICCUP_CYCLES = CNT_W'(`RSFR_HICCUP_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic fault, // synchronised fault level
	input wire logic [1:0] resp, // effective response code
	input wire logic en_toggle, // one-cycle pulse on an enable going low
	output logic stop_q // this rail asks switching to stop
);

	rsfr_pkg::rsfr_state_t state_q; // response state
	logic [CNT_W-1:0] cnt_q; // fault-free time in hiccup wait
	logic is_hiccup; // decoded response
	logic is_latch;

	assign is_hiccup = (resp == rsfr_pkg::RSFR_RESP_HICCUP);
	assign is_latch = (resp == rsfr_pkg::RSFR_RESP_LATCH);

	// state and delay counter; the response is taken at the moment of detection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= rsfr_pkg::RSFR_ST_RUN;
			cnt_q <= '0;
		end
		else if (clk_en)
		begin
			unique case (state_q)
				rsfr_pkg::RSFR_ST_RUN:
				begin
					// flag-only leaves the stage alone
					if (fault && is_hiccup)
						state_q <= rsfr_pkg::RSFR_ST_HOLD;
					else if (fault && is_latch)
						state_q <= rsfr_pkg::RSFR_ST_LATCHED;
				end
				rsfr_pkg::RSFR_ST_HOLD:
				begin
					// fault still present: wait for it to clear
					cnt_q <= '0;
					if (!fault)
						state_q <= rsfr_pkg::RSFR_ST_WAIT;
				end
				rsfr_pkg::RSFR_ST_WAIT:
				begin
					if (fault)
					begin
						// a returning fault restarts the whole delay
						state_q <= rsfr_pkg::RSFR_ST_HOLD;
						cnt_q <= '0;
					end
					else if (cnt_q >= HICCUP_CYCLES - 1'b1)
						state_q <= rsfr_pkg::RSFR_ST_RUN;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				rsfr_pkg::RSFR_ST_LATCHED:
				begin
					// only an enable toggle releases the latch
					if (en_toggle)
						state_q <= rsfr_pkg::RSFR_ST_RUN;
				end
			endcase
		end
	end

	// stop request from a flop, high in every state but run; it follows the state being
	// entered, so the switching gate is not left one cycle behind the response engine
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stop_q <= 1'b0;
		else if (clk_en)
		begin
			unique case (state_q)
				rsfr_pkg::RSFR_ST_RUN:
					stop_q <= fault && (is_hiccup || is_latch);
				rsfr_pkg::RSFR_ST_HOLD:
					stop_q <= 1'b1;
				rsfr_pkg::RSFR_ST_WAIT:
					stop_q <= fault || (cnt_q < HICCUP_CYCLES - 1'b1);
				rsfr_pkg::RSFR_ST_LATCHED:
					stop_q <= ~en_toggle;
			endcase
		end
	end

	AST_STOP_MATCHES_STATE: assert property (@(posedge clk) disable iff (!rst_n)
		stop_q == (state_q != rsfr_pkg::RSFR_ST_RUN))
		else $error("stop request out of step with response state");

	AST_FLAG_KEEPS_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && state_q == rsfr_pkg::RSFR_ST_RUN && !is_hiccup && !is_latch)
		|=> state_q == rsfr_pkg::RSFR_ST_RUN)
		else $error("flag-only response left run state");

	AST_HICCUP_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && state_q == rsfr_pkg::RSFR_ST_WAIT && !fault && cnt_q == HICCUP_CYCLES - 1'b1)
		|=> state_q == rsfr_pkg::RSFR_ST_RUN)
		else $error("hiccup did not resume at end of delay");

	AST_HICCUP_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && state_q == rsfr_pkg::RSFR_ST_WAIT && fault)
		|=> state_q == rsfr_pkg::RSFR_ST_HOLD ##1 (cnt_q == '0 || !clk_en))
		else $error("hiccup delay not restarted by returning fault");

	AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
		(clk_en && state_q == rsfr_pkg::RSFR_ST_LATCHED && !en_toggle)
		|=> state_q == rsfr_pkg::RSFR_ST_LATCHED)
		else $error("latch-off released without enable toggle");

endmodule : rsfr_rail_resp
`default_nettype wire

//--- rsfr_host_model.sv
// system controller side model: flag wire pull-up and the two enable pins
`timescale 1ns/1ps
`default_nettype none

module rsfr_host_model (
	input wire logic clk,
	input wire logic flag_n_o,
	input wire logic flag_oe,
	output wire logic flag_wire,
	output logic pwm_en,
	output logic chip_en
);
	// open-drain wire: pulled up unless the block pulls it low
	assign flag_wire = flag_oe ? flag_n_o : 1'b1;

	// both enables start high so switching may run
	initial
	begin
		pwm_en = 1'b1;
		chip_en = 1'b1;
	end

	// restart after latch-off: one enable goes low for three cycles, changed on the falling edge
	task automatic toggle(input logic use_chip);
		@(negedge clk);
		if (use_chip)
			chip_en = 1'b0;
		else
			pwm_en = 1'b0;
		repeat (3) @(negedge clk);
		pwm_en = 1'b1;
		chip_en = 1'b1;
	endtask : toggle
endmodule : rsfr_host_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the rail fault response block
`timescale 1ns/1ps
`default_nettype none
`include "rsfr_defines.svh"

module tb_top;
	localparam int HC = 20; // shortened hiccup delay, keeps the run short
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_ack;
	logic ind_resp_en = 1'b1;
	logic [1:0] mode_resp = 2'h0;
	logic [2:0] flt = 3'h0; // driver uv, logic ov, logic uv
	wire pwm_en;
	wire chip_en;
	wire flag_wire;
	logic flag_o;
	logic flag_oe;
	logic pwm_run;
	int error_cnt = 0;
	int cmp_count = 0;
	int pos [3] = '{3, 0, 1}; // status bit of each rail

	// 25 MHz clock
	always #20 clk = ~clk;

	rsfr_top #(.CNT_W(8), .HICCUP_CYCLES(8'h14)) i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .ind_resp_en(ind_resp_en), .mode_resp(mode_resp),
		.driver_supply_rail_uv(flt[0]), .logic_supply_rail_ov(flt[1]), .logic_supply_rail_uv(flt[2]),
		.pwm_en(pwm_en), .chip_en(chip_en), .fault_flag_n_i(flag_wire), .fault_flag_n_o(flag_o),
		.fault_flag_oe(flag_oe), .pwm_run(pwm_run));

	rsfr_host_model i_host (.clk(clk), .flag_n_o(flag_o), .flag_oe(flag_oe), .flag_wire(flag_wire),
		.pwm_en(pwm_en), .chip_en(chip_en));

	// wait n falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// compare and count
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one-cycle strobe, answer looked at in the ack cycle
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = ~wr;
		@(negedge clk);
		// ack and read data stand from the taking edge to the next one
		chk("reg_ack", 8'h01, {7'h00, reg_ack});
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : acc

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk("reg_rdata", exp, reg_rdata);
	endtask : rd

	// verdict and end of run
	task automatic test_done;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// raise one rail fault under one code; field or mode pin governs as ind says
	task automatic run_fault(input int r, input logic [1:0] c, input logic ind);
		logic stops;
		logic [1:0] fc;
		stops = (c == 2'h1) || (c == 2'h2);
		fc = ind ? c : c ^ 2'h1; // unused field differs in effect when the mode pin governs
		ind_resp_en = ind;
		mode_resp = ind ? c ^ 2'h1 : c; // likewise the ignored mode pin differs
		acc(1'b1, `RSFR_OFS_RESP_CTRL, 8'({6'h00, fc} << (2 + 2 * r)));
		@(negedge clk);
		flt[r] = 1'b1;
		cyc(5);
		chk("flag_oe", 8'h01, {7'h00, flag_oe});
		chk("pwm_run", {7'h00, ~stops}, {7'h00, pwm_run});
		rd(`RSFR_OFS_FAULT_STAT, 8'h80 | (8'h01 << pos[r]));
		acc(1'b1, `RSFR_OFS_FAULT_STAT, 8'hff);
		rd(`RSFR_OFS_FAULT_STAT, 8'h80 | (8'h01 << pos[r]));
		flt[r] = 1'b0;
		cyc(HC / 2 + 3);
		chk("pwm_run", {7'h00, ~stops}, {7'h00, pwm_run});
		cyc(HC);
		chk("pwm_run", {7'h00, c != 2'h2}, {7'h00, pwm_run});
		if (c == 2'h2)
		begin
			i_host.toggle(ind);
			cyc(8);
			chk("pwm_run", 8'h01, {7'h00, pwm_run});
		end
		acc(1'b1, `RSFR_OFS_FAULT_STAT, 8'hff);
		cyc(4);
		rd(`RSFR_OFS_FAULT_STAT, 8'h00);
		chk("flag_oe", 8'h00, {7'h00, flag_oe});
	endtask : run_fault

	// main sequence
	initial
	begin
		cyc(10);
		rst_n = 1'b1;
		cyc(4);
		rd(`RSFR_OFS_RESP_CTRL, `RSFR_RST_RESP_CTRL);
		rd(`RSFR_OFS_FAULT_STAT, `RSFR_RST_FAULT_STAT);
		rd(8'h00, 8'h00);
		chk("pwm_run", 8'h01, {7'h00, pwm_run});
		acc(1'b1, `RSFR_OFS_RESP_CTRL, 8'he4);
		rd(`RSFR_OFS_RESP_CTRL, 8'he4);
		for (int p = 0; p < 2; p++)
			for (int r = 0; r < 3; r++)
				for (int c = 0; c < 4; c++)
					run_fault(r, 2'(c), p == 0);
		// a returning fault restarts the hiccup delay
		ind_resp_en = 1'b1;
		acc(1'b1, `RSFR_OFS_RESP_CTRL, 8'h10);
		@(negedge clk);
		flt[1] = 1'b1;
		cyc(5);
		flt[1] = 1'b0;
		cyc(10);
		flt[1] = 1'b1;
		cyc(3);
		flt[1] = 1'b0;
		cyc(15);
		chk("pwm_run", 8'h00, {7'h00, pwm_run});
		cyc(15);
		chk("pwm_run", 8'h01, {7'h00, pwm_run});
		test_done();
	end

	// watchdog, far beyond the roughly 1500 cycles the tests need
	initial
	begin
		cyc(20000);
		error_cnt++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
